// ### hw/control_decode.sv
// turns the stored register fields into registered control levels
// assumes register contents are stable flops from the port engine
module control_decode
(
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire encoder_pkg::power_ctrl_t power,
  input  wire encoder_pkg::mode_sel_t   mode,
  input  wire encoder_pkg::out_mode_t   outmode,
  output encoder_pkg::ctrl_t            ctrl
);

  encoder_pkg::ctrl_t ctrl_r;
  encoder_pkg::ctrl_t ctrl_nxt;
  wire logic          is_sd;
  wire logic          is_hd;
  wire logic          is_ddr;
  wire logic [5:0]    dac_bits;

  assign dac_bits = {power.dac6, power.dac5, power.dac4,
                     power.dac3, power.dac2, power.dac1};

  // reserved input codes leave every path off
  assign is_sd  = (mode.input_mode == encoder_pkg::MODE_SD)
               || (mode.input_mode == encoder_pkg::MODE_SD_HD_SDR)
               || (mode.input_mode == encoder_pkg::MODE_SD_HD_DDR);
  assign is_ddr = (mode.input_mode == encoder_pkg::MODE_HD_DDR)
               || (mode.input_mode == encoder_pkg::MODE_SD_HD_DDR);
  assign is_hd  = is_ddr
               || (mode.input_mode == encoder_pkg::MODE_HD_SDR)
               || (mode.input_mode == encoder_pkg::MODE_SD_HD_SDR)
               || (mode.input_mode == encoder_pkg::MODE_ED_54MHZ);

  always_comb
  begin
    ctrl_nxt                = '0;
    ctrl_nxt.sleep          = power.sleep;
    ctrl_nxt.pll_power_down = power.sleep | power.pll_off;
    ctrl_nxt.oversample_off = power.pll_off;
    ctrl_nxt.dac_on         = dac_bits & {6{~power.sleep}};
    ctrl_nxt.sd_path_on     = is_sd;
    ctrl_nxt.hd_path_on     = is_hd;
    ctrl_nxt.hd_ddr         = is_ddr;
    ctrl_nxt.ed_54mhz       = (mode.input_mode == encoder_pkg::MODE_ED_54MHZ);
    // reserved edge codes fall back to chroma on rising
    ctrl_nxt.luma_on_rising = is_ddr
                           && (mode.edge_align == encoder_pkg::EDGE_LUMA_RISING);
    ctrl_nxt.bus_swap       = mode.bus_swap & is_sd;
    ctrl_nxt.black_bar      = outmode.black_bar;
    ctrl_nxt.manual_csc     = outmode.manual_csc;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ctrl_r <= '0;
    else
      ctrl_r <= ctrl_nxt;
  end

  assign ctrl = ctrl_r;

endmodule // control_decode

// ### hw/encoder_pkg.sv
// constants, field layouts and carrier types for the encoder control bank
// assumes a single 10 MHz control clock and serial-port pins sampled on it
package encoder_pkg;

  localparam int         NUM_REGS    = 3;
  localparam int         IDX_W       = 2;
  localparam logic [7:0] PTR_POWER   = 8'h00;
  localparam logic [7:0] PTR_MODE    = 8'h01;
  localparam logic [7:0] PTR_OUTMODE = 8'h02;
  localparam logic [7:0] PTR_LAST    = 8'h02;
  localparam logic [7:0] PTR_MAX     = 8'hff;

  localparam logic [7:0] RST_POWER   = 8'h12;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_OUTMODE = 8'h20;
  localparam logic [7:0] RESET_VALS [NUM_REGS] = '{RST_POWER, RST_MODE, RST_OUTMODE};

  // 7-bit slave address is {ADDR_UPPER, address select pin}
  localparam logic [5:0] ADDR_UPPER  = 6'h35;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;

  localparam logic [2:0] MODE_SD          = 3'h0;
  localparam logic [2:0] MODE_HD_SDR      = 3'h1;
  localparam logic [2:0] MODE_HD_DDR      = 3'h2;
  localparam logic [2:0] MODE_SD_HD_SDR   = 3'h3;
  localparam logic [2:0] MODE_SD_HD_DDR   = 3'h4;
  localparam logic [2:0] MODE_ED_54MHZ    = 3'h7;
  localparam logic [1:0] EDGE_LUMA_RISING = 2'h3;

  typedef struct packed {
    logic dac4;
    logic dac5;
    logic dac6;
    logic dac1;
    logic dac2;
    logic dac3;
    logic pll_off;
    logic sleep;
  } power_ctrl_t;

  typedef struct packed {
    logic       bus_swap;
    logic [2:0] input_mode;
    logic       rsvd3;
    logic [1:0] edge_align;
    logic       rsvd0;
  } mode_sel_t;

  typedef struct packed {
    logic [3:0] upper;
    logic       manual_csc;
    logic       black_bar;
    logic [1:0] rsvd;
  } out_mode_t;

  typedef struct packed {
    logic       sleep;
    logic       pll_power_down;
    logic       oversample_off;
    logic [5:0] dac_on;          // bit 0 is converter 1
    logic       sd_path_on;
    logic       hd_path_on;
    logic       hd_ddr;
    logic       ed_54mhz;
    logic       luma_on_rising;
    logic       bus_swap;
    logic       black_bar;
    logic       manual_csc;
  } ctrl_t;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_SUB      = 9'h008,
    ST_SUB_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WACK     = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RACK     = 9'h100
  } port_state_t;

endpackage

// ### hw/encoder_power_mode_regs.sv
// two-wire serial control port slave with the power and mode register bank
// assumes scl and sda are already synchronous to clock and much slower than it
module encoder_power_mode_regs
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_sel,
  output encoder_pkg::ctrl_t ctrl
);

  encoder_pkg::port_state_t state_r;
  encoder_pkg::port_state_t state_nxt;

  logic       scl_prev_r;
  logic       sda_prev_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       sda_oe_r;
  logic       sda_oe_nxt;
  logic       sda_out_r;
  logic       nack_r;
  logic       nack_nxt;
  logic       wr_en;
  logic [7:0] regs_r [encoder_pkg::NUM_REGS];

  wire logic       scl_rise;
  wire logic       scl_fall;
  wire logic       start_cond;
  wire logic       stop_cond;
  wire logic       byte_done;
  wire logic       take_bit;
  wire logic       byte_end;
  wire logic       addr_match;
  wire logic       rd_bit;
  wire logic       sub_valid;
  wire logic       ptr_valid;
  wire logic [7:0] ptr_inc;
  wire logic [7:0] ptr_rd_adv;
  wire logic [encoder_pkg::IDX_W-1:0] wr_idx;
  wire logic [encoder_pkg::IDX_W-1:0] rd_idx;
  wire logic [7:0] rd_byte;

  // edges judged against last sample; start/stop only while scl stays high
  assign scl_rise   = scl_in & ~scl_prev_r;
  assign scl_fall   = ~scl_in & scl_prev_r;
  assign start_cond = scl_in & scl_prev_r & sda_prev_r & ~sda_in;
  assign stop_cond  = scl_in & scl_prev_r & ~sda_prev_r & sda_in;
  assign byte_done  = (bit_cnt_r == encoder_pkg::BYTE_BITS);
  assign take_bit   = scl_rise & ~byte_done;
  assign byte_end   = scl_fall & byte_done;
  assign addr_match = (shift_r[7:1] == {encoder_pkg::ADDR_UPPER, addr_sel});
  assign rd_bit     = shift_r[0];

  assign sub_valid  = (shift_r <= encoder_pkg::PTR_LAST);
  assign ptr_valid  = (ptr_r <= encoder_pkg::PTR_LAST);
  // pointer stops at all ones rather than wrapping back onto a real register
  assign ptr_inc    = (ptr_r == encoder_pkg::PTR_MAX) ? ptr_r : ptr_r + 8'h01;
  // reads past the top keep returning the highest register
  assign ptr_rd_adv = (ptr_r < encoder_pkg::PTR_LAST) ? ptr_r + 8'h01
                                                      : encoder_pkg::PTR_LAST;
  assign wr_idx     = ptr_r[encoder_pkg::IDX_W-1:0];
  assign rd_idx     = ptr_valid ? ptr_r[encoder_pkg::IDX_W-1:0]
                                : encoder_pkg::PTR_LAST[encoder_pkg::IDX_W-1:0];
  // pointer itself is never a read source
  assign rd_byte    = regs_r[rd_idx];

  always_comb
  begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    sda_oe_nxt  = sda_oe_r;
    nack_nxt    = nack_r;
    wr_en       = 1'b0;
    if (stop_cond)
    begin
      state_nxt  = encoder_pkg::ST_IDLE;
      sda_oe_nxt = 1'b0;
    end
    else if (start_cond)
    begin
      // pointer kept across a repeated start so a read follows the set-up write
      state_nxt   = encoder_pkg::ST_ADDR;
      bit_cnt_nxt = encoder_pkg::CNT_ZERO;
      sda_oe_nxt  = 1'b0;
    end
    else
    begin
      case (state_r)
        encoder_pkg::ST_IDLE:
        begin
          sda_oe_nxt = 1'b0;
        end
        encoder_pkg::ST_ADDR:
        begin
          if (take_bit)
          begin
            shift_nxt   = {shift_r[6:0], sda_in};
            bit_cnt_nxt = bit_cnt_r + encoder_pkg::CNT_ONE;
          end
          else if (byte_end)
          begin
            bit_cnt_nxt = encoder_pkg::CNT_ZERO;
            sda_oe_nxt  = addr_match;
            state_nxt   = addr_match ? encoder_pkg::ST_ADDR_ACK : encoder_pkg::ST_IDLE;
          end
        end
        encoder_pkg::ST_ADDR_ACK:
        begin
          if (scl_fall && rd_bit)
          begin
            shift_nxt   = {rd_byte[6:0], 1'b1};
            sda_oe_nxt  = ~rd_byte[7];
            bit_cnt_nxt = encoder_pkg::CNT_ONE;
            state_nxt   = encoder_pkg::ST_RDATA;
          end
          else if (scl_fall)
          begin
            sda_oe_nxt = 1'b0;
            state_nxt  = encoder_pkg::ST_SUB;
          end
        end
        encoder_pkg::ST_SUB:
        begin
          if (take_bit)
          begin
            shift_nxt   = {shift_r[6:0], sda_in};
            bit_cnt_nxt = bit_cnt_r + encoder_pkg::CNT_ONE;
          end
          else if (byte_end)
          begin
            bit_cnt_nxt = encoder_pkg::CNT_ZERO;
            sda_oe_nxt  = sub_valid;
            ptr_nxt     = shift_r;
            state_nxt   = sub_valid ? encoder_pkg::ST_SUB_ACK : encoder_pkg::ST_IDLE;
          end
        end
        encoder_pkg::ST_SUB_ACK, encoder_pkg::ST_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_nxt = 1'b0;
            state_nxt  = encoder_pkg::ST_WDATA;
          end
        end
        encoder_pkg::ST_WDATA:
        begin
          if (take_bit)
          begin
            shift_nxt   = {shift_r[6:0], sda_in};
            bit_cnt_nxt = bit_cnt_r + encoder_pkg::CNT_ONE;
          end
          else if (byte_end)
          begin
            // a byte beyond the top register is dropped and refused
            bit_cnt_nxt = encoder_pkg::CNT_ZERO;
            wr_en       = ptr_valid;
            sda_oe_nxt  = ptr_valid;
            ptr_nxt     = ptr_inc;
            state_nxt   = ptr_valid ? encoder_pkg::ST_WACK : encoder_pkg::ST_IDLE;
          end
        end
        encoder_pkg::ST_RDATA:
        begin
          if (scl_fall && byte_done)
          begin
            sda_oe_nxt  = 1'b0;
            bit_cnt_nxt = encoder_pkg::CNT_ZERO;
            ptr_nxt     = ptr_rd_adv;
            state_nxt   = encoder_pkg::ST_RACK;
          end
          else if (scl_fall)
          begin
            sda_oe_nxt  = ~shift_r[7];
            shift_nxt   = {shift_r[6:0], 1'b1};
            bit_cnt_nxt = bit_cnt_r + encoder_pkg::CNT_ONE;
          end
        end
        encoder_pkg::ST_RACK:
        begin
          if (scl_rise)
            nack_nxt = sda_in;
          else if (scl_fall && nack_r)
            state_nxt = encoder_pkg::ST_IDLE;
          else if (scl_fall)
          begin
            shift_nxt   = {rd_byte[6:0], 1'b1};
            sda_oe_nxt  = ~rd_byte[7];
            bit_cnt_nxt = encoder_pkg::CNT_ONE;
            state_nxt   = encoder_pkg::ST_RDATA;
          end
        end
        default:
        begin
          state_nxt  = encoder_pkg::ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r    <= encoder_pkg::ST_IDLE;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      bit_cnt_r  <= encoder_pkg::CNT_ZERO;
      shift_r    <= 8'h00;
      ptr_r      <= 8'h00;
      sda_oe_r   <= 1'b0;
      sda_out_r  <= 1'b0;
      nack_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      scl_prev_r <= scl_in;
      sda_prev_r <= sda_in;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      ptr_r      <= ptr_nxt;
      sda_oe_r   <= sda_oe_nxt;
      sda_out_r  <= 1'b0;
      nack_r     <= nack_nxt;
    end
  end

  // sleep does not gate the port, so the bank stays reachable while asleep
  genvar g;
  generate
    for (g = 0; g < encoder_pkg::NUM_REGS; g = g + 1)
    begin : g_reg
      always_ff @(posedge clock)
      begin
        if (reset)
          regs_r[g] <= encoder_pkg::RESET_VALS[g];
        else if (wr_en && (wr_idx == (encoder_pkg::IDX_W)'(g)))
          regs_r[g] <= shift_r;
      end
    end
  endgenerate

  control_decode u_decode
  (
    .clock   (clock),
    .reset   (reset),
    .power   (encoder_pkg::power_ctrl_t'(regs_r[encoder_pkg::PTR_POWER[encoder_pkg::IDX_W-1:0]])),
    .mode    (encoder_pkg::mode_sel_t'(regs_r[encoder_pkg::PTR_MODE[encoder_pkg::IDX_W-1:0]])),
    .outmode (encoder_pkg::out_mode_t'(regs_r[encoder_pkg::PTR_OUTMODE[encoder_pkg::IDX_W-1:0]])),
    .ctrl    (ctrl)
  );

  assign sda_out = sda_out_r;
  assign sda_oe  = sda_oe_r;

endmodule // encoder_power_mode_regs

// ### testbench/encoder_power_mode_regs_tb.sv
// self-checking bench for the encoder control bank
// assumes the host model owns scl and data; the bench drives reset and addr_sel
module encoder_power_mode_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               addr_sel = 1'b0;
  logic               scl;
  logic               sda;
  logic               sda_out;
  logic               sda_oe;
  encoder_pkg::ctrl_t ctrl;
  encoder_pkg::ctrl_t mk;
  encoder_pkg::ctrl_t e;
  encoder_pkg::ctrl_t c;
  logic [31:0]        lfsr_r = 32'hda6d9acb;
  logic [7:0]         wd [4];
  logic [7:0]         rq [4];
  logic [7:0]         ak;
  logic [7:0]         m1;
  logic [7:0]         rst [3] = '{8'h12, 8'h00, 8'h20};
  logic [2:0]         modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int                 err_total = 0;
  int                 compares = 0;

  always #50 clock = ~clock;

  host_port_model host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  encoder_power_mode_regs dut (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .ctrl(ctrl));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] dev(input logic rw);
    return {encoder_pkg::ADDR_UPPER, addr_sel, rw};
  endfunction

  function automatic encoder_pkg::ctrl_t exp_ctrl(input logic [7:0] p, m, o);
    encoder_pkg::ctrl_t x;
    logic [2:0]         im;
    im = m[6:4];
    x.sleep = p[0];
    x.pll_power_down = p[1] | p[0];
    x.oversample_off = p[1];
    x.dac_on = p[0] ? 6'h00 : {p[5], p[6], p[7], p[2], p[3], p[4]};
    x.sd_path_on = (im == 3'h0) || (im == 3'h3) || (im == 3'h4);
    x.hd_path_on = (im != 3'h0) && (im != 3'h5) && (im != 3'h6);
    x.hd_ddr = (im == 3'h2) || (im == 3'h4);
    x.ed_54mhz = (im == 3'h7);
    x.luma_on_rising = x.hd_ddr && (m[2:1] == 2'h3);
    x.bus_swap = m[7] && x.sd_path_on;
    x.black_bar = o[2];
    x.manual_csc = o[3];
    return x;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    compares++;
    if (sn !== ex)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] d, input logic [7:0] sub, input int n);
    logic [7:0] q;
    ak = 8'h00;
    host.cond(1'b0);
    host.byte_io(d, 1'b1, q, ak[0]);
    host.byte_io(sub, 1'b1, q, ak[1]);
    for (int k = 0; k < n; k++)
      host.byte_io(wd[k], 1'b1, q, ak[k + 2]);
    host.cond(1'b1);
  endtask

  task automatic rd(input logic [7:0] sub, input int n, input logic has_sub);
    logic [7:0] q;
    logic       a;
    host.cond(1'b0);
    if (has_sub)
    begin
      host.byte_io(dev(1'b0), 1'b1, q, a);
      host.byte_io(sub, 1'b1, q, a);
      host.cond(1'b0);
    end
    host.byte_io(dev(1'b1), 1'b1, q, a);
    for (int k = 0; k < n; k++)
      host.byte_io(8'hff, k == n - 1, rq[k], a);
    host.cond(1'b1);
  endtask

  task automatic chk_reset();
    repeat (3) @(posedge clock);
    chk("ctrl", 32'(exp_ctrl(rst[0], rst[1], rst[2])), 32'(ctrl));
    rd(8'h00, 3, 1'b1);
    for (int k = 0; k < 3; k++)
      chk("reg", 32'(rst[k]), 32'(rq[k]));
  endtask

  initial
  begin
    repeat (50000) @(posedge clock);
    err_total++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    chk_reset();
    for (int i = 0; i < 12; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      addr_sel <= lfsr_r[31];
      wd[0] = lfsr_r[7:0];
      wd[1] = {lfsr_r[8], modes[i % 6], lfsr_r[9], (i < 6) ? 2'h0 : 2'h3, lfsr_r[10]};
      // pattern enable lives outside this bank; the bar, manual_csc and upper bits are all driven at random here
      wd[2] = {lfsr_r[15:11], lfsr_r[16], 2'h0};
      @(posedge clock);
      wr(dev(1'b0), 8'h00, 3);
      chk("ack", 32'h1f, 32'(ak));
      mk = '1;
      e = exp_ctrl(wd[0], wd[1], wd[2]) & mk;
      c = ctrl & mk;
      chk("power", 32'(e[16:8]), 32'(c[16:8]));
      chk("mode", 32'(e[7:0]), 32'(c[7:0]));
      rd(8'h00, 3, 1'b1);
      for (int k = 0; k < 3; k++)
        chk("reg", 32'(wd[k]), 32'(rq[k]));
    end
    // write runs past the top register: last byte refused, highest repeats on read
    m1 = wd[1];
    wd[0] = 8'h2c;
    wd[1] = 8'hff;
    wr(dev(1'b0), 8'h02, 2);
    chk("ack", 32'h07, 32'(ak));
    rd(8'h01, 3, 1'b1);
    chk("reg", 32'(m1), 32'(rq[0]));
    chk("reg", 32'h2c, 32'(rq[1]));
    chk("reg", 32'h2c, 32'(rq[2]));
    wr(dev(1'b0), 8'h03, 1);
    chk("ack", 32'h01, 32'(ak));
    wr({encoder_pkg::ADDR_UPPER, ~addr_sel, 1'b0}, 8'h00, 1);
    chk("ack", 32'h00, 32'(ak));
    wr(dev(1'b0), 8'h01, 0);
    rd(8'h00, 1, 1'b0);
    chk("ptr", 32'(m1), 32'(rq[0]));
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    chk_reset();
    close_out();
  end
endmodule // encoder_power_mode_regs_tb

bind encoder_power_mode_regs encoder_regs_checker chk_i (.clock(clock), .reset(reset),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_sel(addr_sel), .ctrl(ctrl));

// ### testbench/encoder_regs_checker.sv
// concurrent checks on the encoder control bank ports
// assumes one clock domain and a synchronous active-high reset
module encoder_regs_checker
(
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  input wire logic               addr_sel,
  input wire encoder_pkg::ctrl_t ctrl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence

  sequence s_release;
    $fell(reset);
  endsequence

  a_sleep_all_off: assert property (
    ctrl.sleep |-> (ctrl.dac_on == 6'h00) && ctrl.pll_power_down)
    else $error("converter or pll active in sleep");
  a_pll_follows_bits: assert property (
    ctrl.pll_power_down == (ctrl.oversample_off || ctrl.sleep))
    else $error("pll power down disagrees with its bits");
  a_luma_needs_ddr: assert property (
    ctrl.luma_on_rising |-> ctrl.hd_ddr)
    else $error("edge alignment outside double rate mode");
  a_ed54_alone: assert property (
    ctrl.ed_54mhz |-> !ctrl.sd_path_on && !ctrl.hd_ddr)
    else $error("54 MHz mode mixed with other paths");
  a_ddr_has_hd: assert property (
    ctrl.hd_ddr |-> ctrl.hd_path_on)
    else $error("double rate without hd path");
  a_swap_sd_only: assert property (
    ctrl.bus_swap |-> ctrl.sd_path_on)
    else $error("bus swap without sd input");
  a_reset_loads: assert property (
    s_release |-> ##[0:2] (ctrl.dac_on == 6'h01 && ctrl.pll_power_down
                           && ctrl.oversample_off && ctrl.sd_path_on && !ctrl.sleep))
    else $error("controls do not show reset values");
  a_quiet_after_start: assert property (
    s_start |-> ##1 !sda_oe [*8])
    else $error("data driven during address bits");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed near scl high");
  // open drain: the line may only ever be pulled low
  a_open_drain_low: assert property (
    !sda_out)
    else $error("data line driven high");
endmodule // encoder_regs_checker

// ### testbench/host_port_model.sv
// host model for the two-wire control port: drives scl and data
// assumes the device pulls data low via sda_oe; a released line floats high
module host_port_model
(
  input  wire logic clock,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_r = 1'b1;
  initial scl = 1'b1;
  // pull-up, so a released line never shows the last bit
  assign sda = drv_r & ~sda_oe;

  task automatic half();
    repeat (4) @(posedge clock);
  endtask

  // start for b 0, stop for b 1
  task automatic cond(input logic b);
    drv_r <= ~b;
    half();
    scl <= 1'b1;
    half();
    drv_r <= b;
    half();
    if (!b)
    begin
      scl <= 1'b0;
      half();
    end
  endtask

  // data moves at least one clock after scl falls, never while scl is high
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock);
    drv_r <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q,
                         output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m, r);
    a = ~r;
  endtask
endmodule // host_port_model
